//--- rtl/pir_top.sv
// Notes on behaviour
// RULE1: each peripheral unit except debug gets a software level 0..15.
// RULE2: the debug source always runs at level 15.
// RULE3: taking an interrupt never alters the cpu mask level bits.
// RULE4: timer and calendar wake standby only above mask and with 32k oscillator.
// RULE5: accepted source identity is reported in two event code registers.
// RULE6: each source has its own event code, stored on acceptance.
// RULE7: every source points the cpu at one common entry address.
// RULE8: five priority setting registers hold all programmable levels 0..15.
// RULE9: reset clears every programmable level to zero.
// RULE10: equal levels resolve by fixed source order, lower index first.
// RULE11: a source at level zero is ignored.
// RULE12: higher level number is higher priority, level 1 lowest active.
// RULE13: a request goes to the cpu only above the cpu mask level.
`include "pir_defs.svh"
module pir_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [`PIR_NUM_PERIPH-1:0] periph_req,
	input wire logic debug_req,
	input wire logic [`PIR_NUM_EXT-1:0] ext_req_pin,
	input wire logic [3:0] cpu_mask_level,
	input wire logic cpu_int_ack,
	input wire logic standby_mode,
	input wire logic osc32k_in_use,
	output logic cpu_int_req,
	output pir_pkg::pir_lvl_t cpu_int_level,
	output logic [31:0] cpu_int_vector,
	output logic [11:0] event_code_out,
	output logic wake_req,
	output logic int_out
);
	import pir_pkg::*;

	// ================================================================
	// state
	pir_state_t s_ff;
	pir_state_t nxt_s;

	logic [`PIR_NUM_EXT-1:0] ext_req;
	logic [`PIR_NUM_SRC-1:0] src_req;
	logic [`PIR_NUM_SRC*4-1:0] src_lvl;
	logic win_valid;
	pir_src_t win_idx;
	pir_lvl_t win_lvl;
	logic [`PIR_NUM_WAKE-1:0] wake_hit;

	// ================================================================
	// pin requests come from outside the clock domain
	pir_sync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.async_in(ext_req_pin),
		.sync_out(ext_req)
	);

	// ================================================================
	// source levels
	// source 0 is debug; units 0..11 sit in regs a, b, e; 12..19 in c, d
	assign src_req = {ext_req, periph_req, debug_req};
	// RULE2 debug level is a constant
	assign src_lvl[3:0] = `PIR_DEBUG_LEVEL;

	genvar g;
	generate
		for (g = 0; g < `PIR_NUM_UNITS; g++) begin : g_unit
			// RULE1 unit level from its nibble
			assign src_lvl[(g+1)*4 +: 4] = s_ff.prio[g/4][(3-(g%4))*4 +: 4];
		end
	endgenerate

	pir_arb u_arb (
		.src_req(src_req),
		.src_lvl(src_lvl),
		.win_valid(win_valid),
		.win_idx(win_idx),
		.win_lvl(win_lvl)
	);

	generate
		for (g = 0; g < `PIR_NUM_WAKE; g++) begin : g_wake
			// RULE4 only timer and calendar units may wake
			assign wake_hit[g] = periph_req[g] && (src_lvl[(g+1)*4 +: 4] > cpu_mask_level);
		end
	endgenerate

	// ================================================================
	// next state
	always_comb begin
		logic [1:0] st_set;
		logic [2:0] widx;
		nxt_s = s_ff;
		st_set = 2'b00;
		widx = 3'd0;
		// register order a, b, e, c, d follows the unit numbering
		case (reg_addr)
			`PIR_OFF_PRIO_A: widx = 3'd1;
			`PIR_OFF_PRIO_B: widx = 3'd2;
			`PIR_OFF_PRIO_E: widx = 3'd3;
			`PIR_OFF_PRIO_C: widx = 3'd4;
			`PIR_OFF_PRIO_D: widx = 3'd5;
			default: widx = 3'd0;
		endcase

		// RULE8 software writes the five setting registers
		if (reg_wr && widx != 3'd0) begin
			nxt_s.prio[widx-3'd1] = reg_wdata[15:0];
		end
		if (reg_wr && reg_addr == `PIR_OFF_INT_MASK) begin
			nxt_s.msk = reg_wdata[1:0];
		end

		// RULE13 forward only above the cpu mask level
		nxt_s.cpu_req = win_valid && (win_lvl > cpu_mask_level);
		// the level is kept even when blocked, so the state read shows the winner
		nxt_s.cpu_lvl = win_lvl;
		nxt_s.win = win_idx;
		// RULE7 one common entry for all sources
		nxt_s.vec = `PIR_VECTOR_ADDR;

		// RULE5 latch identity of the accepted source
		if (cpu_int_ack && s_ff.cpu_req) begin
			// RULE6 distinct code per source
			nxt_s.evt_pri = pir_evt_code(s_ff.win);
			nxt_s.evt_sec = pir_evt_code(s_ff.win);
			st_set[`PIR_ST_ACCEPT] = 1'b1;
		end

		// the live mask is used, so raising it cancels a pending wake at the next clock edge
		// RULE4 wake needs standby and the 32k oscillator
		nxt_s.wake = standby_mode && osc32k_in_use && (|wake_hit);
		if (nxt_s.wake && !s_ff.wake) begin
			st_set[`PIR_ST_WAKE] = 1'b1;
		end

		// write one clears; a same-cycle event still sets
		if (reg_wr && reg_addr == `PIR_OFF_INT_STAT) begin
			nxt_s.st = s_ff.st & ~reg_wdata[1:0];
		end
		nxt_s.st = nxt_s.st | st_set;
		nxt_s.irq = |(nxt_s.st & nxt_s.msk);

		// read data stand for exactly one cycle
		nxt_s.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`PIR_OFF_PRIO_A: nxt_s.rdata = {16'h0000, s_ff.prio[0]};
				`PIR_OFF_PRIO_B: nxt_s.rdata = {16'h0000, s_ff.prio[1]};
				`PIR_OFF_PRIO_E: nxt_s.rdata = {16'h0000, s_ff.prio[2]};
				`PIR_OFF_PRIO_C: nxt_s.rdata = {16'h0000, s_ff.prio[3]};
				`PIR_OFF_PRIO_D: nxt_s.rdata = {16'h0000, s_ff.prio[4]};
				`PIR_OFF_EVT_PRI: nxt_s.rdata = {20'h0_0000, s_ff.evt_pri};
				`PIR_OFF_EVT_SEC: nxt_s.rdata = {20'h0_0000, s_ff.evt_sec};
				`PIR_OFF_INT_STAT: nxt_s.rdata = {30'h0, s_ff.st};
				`PIR_OFF_INT_MASK: nxt_s.rdata = {30'h0, s_ff.msk};
				// RULE3 mask level is only observed, never driven
				`PIR_OFF_STATE: nxt_s.rdata = {17'h0, s_ff.win, s_ff.wake,
					s_ff.cpu_req, s_ff.cpu_lvl, cpu_mask_level};
				default: nxt_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ================================================================
	// registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// RULE9 levels clear at reset
			s_ff.prio <= {5{`PIR_PRIO_RST}};
			s_ff.evt_pri <= `PIR_EVT_RST;
			s_ff.evt_sec <= `PIR_EVT_RST;
			s_ff.st <= 2'b00;
			s_ff.msk <= 2'b00;
			s_ff.rdata <= 32'h0000_0000;
			s_ff.irq <= 1'b0;
			s_ff.cpu_req <= 1'b0;
			s_ff.cpu_lvl <= 4'h0;
			s_ff.win <= 5'h00;
			s_ff.wake <= 1'b0;
			s_ff.vec <= `PIR_VECTOR_ADDR;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign reg_rdata = s_ff.rdata;
	assign cpu_int_req = s_ff.cpu_req;
	assign cpu_int_level = s_ff.cpu_lvl;
	assign cpu_int_vector = s_ff.vec;
	assign event_code_out = s_ff.evt_pri;
	assign wake_req = s_ff.wake;
	assign int_out = s_ff.irq;

	// ================================================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_req_above_mask: assert property ( // RULE13
		(win_valid && win_lvl > cpu_mask_level) |=> cpu_int_req)
		else $error("qualified request not forwarded");

	a_req_blocked: assert property ( // RULE13
		!(win_valid && win_lvl > cpu_mask_level) |=> !cpu_int_req)
		else $error("request forwarded at or below mask level");

	a_debug_fixed: assert property ( // RULE2
		(debug_req && cpu_mask_level != 4'hf) |=> cpu_int_req && cpu_int_level == 4'hf)
		else $error("debug source not at level fifteen");

	a_zero_masked: assert property ( // RULE11
		(s_ff.prio == '0 && !debug_req) |=> !cpu_int_req)
		else $error("level zero source reached the cpu");

	a_prio_hold: assert property ( // RULE8
		!reg_wr |=> $stable(s_ff.prio))
		else $error("priority changed without a write");

	a_evt_latch: assert property ( // RULE6
		(cpu_int_ack && cpu_int_req) |=>
		event_code_out == pir_evt_code($past(s_ff.win)) && s_ff.evt_sec == event_code_out)
		else $error("event code not latched for accepted source");

	a_tie_order: assert property ( // RULE10
		!(src_req[1] && src_req[2] && src_lvl[7:4] == src_lvl[11:8] && win_idx == 5'd2))
		else $error("tie resolved against default order");

	a_wake_gate: assert property ( // RULE4
		!(standby_mode && osc32k_in_use) |=> !wake_req)
		else $error("wake without standby and 32k oscillator");

	a_vector_common: assert property ( // RULE7
		cpu_int_req |-> cpu_int_vector == `PIR_VECTOR_ADDR)
		else $error("entry address differs between sources");

	a_level_active: assert property ( // RULE12
		cpu_int_req |-> cpu_int_level >= 4'h1)
		else $error("request forwarded with level zero");

	// ================================================================
	// checks on the register side

	a_prio_write_a: assert property ( // RULE8
		(reg_wr && reg_addr == `PIR_OFF_PRIO_A) |=>
		{16'h0000, s_ff.prio[0]} == ($past(reg_wdata) & 32'h0000_ffff))
		else $error("setting register a not written");

	a_prio_write_e: assert property ( // RULE1
		(reg_wr && reg_addr == `PIR_OFF_PRIO_E) |=>
		{16'h0000, s_ff.prio[2]} == ($past(reg_wdata) & 32'h0000_ffff))
		else $error("setting register e not written");

	a_rdata_pulse: assert property ( // RULE8
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside the answer cycle");

	a_mask_seen: assert property ( // RULE3
		(reg_rd && reg_addr == `PIR_OFF_STATE) |=>
		reg_rdata[3:0] == $past(cpu_mask_level))
		else $error("state read does not show the cpu mask level");

	// ================================================================
	// checks on status, event codes and the cpu request level

	a_set_wins: assert property ( // RULE5
		(cpu_int_ack && cpu_int_req) |=> s_ff.st[`PIR_ST_ACCEPT])
		else $error("accept status lost");

	a_stat_clear: assert property ( // RULE5
		(reg_wr && reg_addr == `PIR_OFF_INT_STAT && reg_wdata[0] &&
		!(cpu_int_ack && cpu_int_req)) |=> !s_ff.st[`PIR_ST_ACCEPT])
		else $error("accept status not cleared by write one");

	a_evt_hold: assert property ( // RULE5
		!(cpu_int_ack && cpu_int_req) |=> $stable(s_ff.evt_pri) && $stable(s_ff.evt_sec))
		else $error("event code changed without an accepted request");

	a_idle_level: assert property ( // RULE11
		!win_valid |=> cpu_int_level == 4'h0)
		else $error("level reported with no valid request");

	a_req_level: assert property ( // RULE13
		cpu_int_req |-> cpu_int_level > $past(cpu_mask_level))
		else $error("request level not above the mask");

	// ================================================================
	// checks on standby wake

	a_wake_set: assert property ( // RULE4
		(standby_mode && osc32k_in_use && (|wake_hit)) |=> wake_req)
		else $error("qualified wake not raised");

	a_wake_mask: assert property ( // RULE4
		!(|wake_hit) |=> !wake_req)
		else $error("wake raised at or below the mask level");

	a_wake_status: assert property ( // RULE4
		(!wake_req ##1 wake_req) |-> s_ff.st[`PIR_ST_WAKE])
		else $error("wake status not set on rising wake");

endmodule

//--- rtl/pir_defs.svh
`ifndef PIR_DEFS_SVH
`define PIR_DEFS_SVH

// ====================================================================
// sizes
`define PIR_NUM_UNITS 20
`define PIR_NUM_PERIPH 12
`define PIR_NUM_EXT 8
`define PIR_NUM_SRC 21
`define PIR_NUM_WAKE 4

// ====================================================================
// register offsets (byte addresses)
`define PIR_OFF_PRIO_A 8'h00
`define PIR_OFF_PRIO_B 8'h04
`define PIR_OFF_PRIO_C 8'h08
`define PIR_OFF_PRIO_D 8'h0c
`define PIR_OFF_PRIO_E 8'h10
`define PIR_OFF_EVT_PRI 8'h14
`define PIR_OFF_EVT_SEC 8'h18
`define PIR_OFF_INT_STAT 8'h1c
`define PIR_OFF_INT_MASK 8'h20
`define PIR_OFF_STATE 8'h24

// ====================================================================
// fields and reset values
`define PIR_PRIO_RST 16'h0000
`define PIR_EVT_RST 12'h000
`define PIR_ST_ACCEPT 0
`define PIR_ST_WAKE 1
`define PIR_DEBUG_LEVEL 4'hf
`define PIR_EVT_BASE 12'h400
`define PIR_EVT_STEP 12'h020
`define PIR_VECTOR_ADDR 32'h0000_0600

`endif

//--- rtl/pir_pkg.sv
`include "pir_defs.svh"

package pir_pkg;

	typedef logic [4:0] pir_src_t;
	typedef logic [3:0] pir_lvl_t;

	typedef struct packed {
		logic [4:0][15:0] prio;
		logic [11:0] evt_pri;
		logic [11:0] evt_sec;
		logic [1:0] st;
		logic [1:0] msk;
		logic [31:0] rdata;
		logic irq;
		logic cpu_req;
		pir_lvl_t cpu_lvl;
		pir_src_t win;
		logic wake;
		logic [31:0] vec;
	} pir_state_t;

	// one distinct code per source index
	function automatic logic [11:0] pir_evt_code(input pir_src_t s);
		logic [11:0] c;
		c = `PIR_EVT_BASE + ({7'h00, s} * `PIR_EVT_STEP);
		return c;
	endfunction

endpackage

//--- rtl/pir_sync.sv
`include "pir_defs.svh"

module pir_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [`PIR_NUM_EXT-1:0] async_in,
	output logic [`PIR_NUM_EXT-1:0] sync_out
);
	import pir_pkg::*;

	logic [`PIR_NUM_EXT-1:0] meta_ff;
	logic [`PIR_NUM_EXT-1:0] sync_ff;

	// first stage is read by the second stage only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule

//--- rtl/pir_arb.sv
`include "pir_defs.svh"

module pir_arb (
	input wire logic [`PIR_NUM_SRC-1:0] src_req,
	input wire logic [`PIR_NUM_SRC*4-1:0] src_lvl,
	output logic win_valid,
	output pir_pkg::pir_src_t win_idx,
	output pir_pkg::pir_lvl_t win_lvl
);
	import pir_pkg::*;

	pir_lvl_t eff [`PIR_NUM_SRC];

	genvar g;
	generate
		for (g = 0; g < `PIR_NUM_SRC; g++) begin : g_eff
			// RULE11 level zero masks
			assign eff[g] = src_req[g] ? src_lvl[g*4 +: 4] : 4'h0;
		end
	endgenerate

	always_comb begin
		win_idx = '0;
		win_lvl = 4'h0;
		// RULE10 strict compare keeps earlier index
		for (int i = 0; i < `PIR_NUM_SRC; i++) begin
			if (eff[i] > win_lvl) begin
				win_lvl = eff[i];
				win_idx = pir_src_t'(i);
			end
		end
		// RULE12 higher number wins
		win_valid = (win_lvl != 4'h0);
	end

endmodule

//--- tb/pir_cpu_model.sv
module pir_cpu_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ack_en,
	input wire logic slow,
	input wire logic cpu_int_req,
	output logic cpu_int_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_ff;
	// ====================================================================
	// core side: answers a request at once or after two stall cycles
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_ff <= 2'h0;
			cpu_int_ack <= 1'b0;
		end else begin
			cpu_int_ack <= 1'b0;
			// never ack twice in a row, the resolver needs a cycle to move on
			if (ack_en && cpu_int_req && !cpu_int_ack) begin
				if (!slow || wait_ff == 2'h2) begin
					cpu_int_ack <= 1'b1;
					wait_ff <= 2'h0;
				end else begin
					wait_ff <= wait_ff + 2'h1;
				end
			end
		end
	end
endmodule

//--- tb/test_peripheral_irq_priority_resolver.sv
module test_peripheral_irq_priority_resolver;
	timeunit 1ns;
	timeprecision 1ps;
	import pir_pkg::*;
	typedef struct packed {
		logic [15:0] pa;
		logic [11:0] pr;
		logic dbg;
		logic [3:0] msk;
		logic req;
		logic [3:0] lvl;
	} pir_row_t;
	logic clk = 1'b0;
	logic rst_b, reg_wr, reg_rd, debug_req, cpu_int_ack, standby_mode, osc32k_in_use;
	logic ack_en, slow, cpu_int_req, wake_req, int_out;
	logic [7:0] reg_addr, ext_req_pin;
	logic [31:0] reg_wdata, reg_rdata, cpu_int_vector, d;
	logic [11:0] periph_req, event_code_out;
	logic [3:0] cpu_mask_level;
	pir_lvl_t cpu_int_level;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	pir_row_t rows [6] = '{
		'{16'h5000, 12'h001, 1'b0, 4'h2, 1'b1, 4'h5},
		'{16'h5000, 12'h001, 1'b0, 4'h5, 1'b0, 4'h0},
		'{16'h0000, 12'h001, 1'b0, 4'h0, 1'b0, 4'h0},
		'{16'h0000, 12'h000, 1'b1, 4'he, 1'b1, 4'hf},
		'{16'h5300, 12'h003, 1'b0, 4'h0, 1'b1, 4'h5},
		'{16'h0400, 12'h002, 1'b0, 4'h3, 1'b1, 4'h4}};

	pir_top i_pir_top (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
		.debug_req(debug_req), .ext_req_pin(ext_req_pin), .cpu_mask_level(cpu_mask_level),
		.cpu_int_ack(cpu_int_ack), .standby_mode(standby_mode),
		.osc32k_in_use(osc32k_in_use), .cpu_int_req(cpu_int_req),
		.cpu_int_level(cpu_int_level), .cpu_int_vector(cpu_int_vector),
		.event_code_out(event_code_out), .wake_req(wake_req), .int_out(int_out));
	pir_cpu_model i_pir_cpu_model (.clk(clk), .rst_b(rst_b), .ack_en(ack_en), .slow(slow),
		.cpu_int_req(cpu_int_req), .cpu_int_ack(cpu_int_ack));

	always #2 clk = ~clk;

	// ====================================================================
	// helpers
	task automatic end_sim();
		if (err_total == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe; take them mid-cycle, end on an edge
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
		@(posedge clk);
	endtask

	task automatic accept(input logic [11:0] req);
		periph_req <= req;
		ack_en <= 1'b1;
		repeat (8) @(posedge clk);
		ack_en <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// generous ceiling: the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end

	// ====================================================================
	// main sequence
	initial begin
		{rst_b, reg_wr, reg_rd, debug_req, standby_mode, osc32k_in_use, ack_en, slow} = 8'h00;
		reg_addr = 8'h00;
		ext_req_pin = 8'h00;
		reg_wdata = 32'h0;
		periph_req = 12'h000;
		cpu_mask_level = 4'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(8'(i * 4), d);
			chk(d, 32'h0);
		end
		chk(cpu_int_vector, 32'h600);
		foreach (rows[i]) begin
			wr(8'h00, {16'h0, rows[i].pa});
			periph_req <= rows[i].pr;
			debug_req <= rows[i].dbg;
			cpu_mask_level <= rows[i].msk;
			repeat (3) @(posedge clk);
			chk({31'h0, cpu_int_req}, {31'h0, rows[i].req});
			if (rows[i].req)
				chk({28'h0, cpu_int_level}, {28'h0, rows[i].lvl});
		end
		periph_req <= 12'h000;
		cpu_mask_level <= 4'h1;
		wr(8'h00, 32'h3300);
		wr(8'h20, 32'h1);
		accept(12'h003);
		chk({20'h0, event_code_out}, 32'h420);
		rd(8'h18, d);
		chk(d, 32'h420);
		slow <= 1'b1;
		accept(12'h002);
		chk({20'h0, event_code_out}, 32'h440);
		rd(8'h24, d);
		chk(d, 32'h931);
		chk({31'h0, int_out}, 32'h1);
		periph_req <= 12'h000;
		wr(8'h1c, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, int_out}, 32'h0);
		wr(8'h00, 32'h5000);
		periph_req <= 12'h001;
		cpu_mask_level <= 4'h2;
		standby_mode <= 1'b1;
		osc32k_in_use <= 1'b1;
		repeat (3) @(posedge clk);
		chk({31'h0, wake_req}, 32'h1);
		osc32k_in_use <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, wake_req}, 32'h0);
		osc32k_in_use <= 1'b1;
		cpu_mask_level <= 4'h5;
		repeat (3) @(posedge clk);
		chk({31'h0, wake_req}, 32'h0);
		// every setting register keeps its own word
		for (int i = 0; i < 5; i++) begin
			wr(8'(i * 4), 32'h1111 * (i + 1));
			rd(8'(i * 4), d);
			chk(d, 32'h1111 * (i + 1));
		end
		// pin source 0 sits in the top nibble of register c, behind the synchroniser
		periph_req <= 12'h000;
		standby_mode <= 1'b0;
		cpu_mask_level <= 4'h3;
		wr(8'h08, 32'h7000);
		ext_req_pin <= 8'h01;
		accept(12'h000);
		chk({20'h0, event_code_out}, 32'h5a0);
		chk({28'h0, cpu_int_level}, 32'h7);
		// reset in mid-run clears the levels and the codes
		ext_req_pin <= 8'h00;
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd(8'h08, d);
		chk(d, 32'h0);
		chk({20'h0, event_code_out}, 32'h0);
		chk({31'h0, cpu_int_req}, 32'h0);
		wr(8'h40, 32'hffff);
		rd(8'h40, d);
		chk(d, 32'h0);
		end_sim();
	end
endmodule
